// ==== src/pireg_pkg.sv ====
// shared constants, register map and carrier types of the process regulator
package pireg_pkg;

    // ==============================
    // bus and data widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // ==============================
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_PGAIN = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IGAIN = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_SETPT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_DEADB = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_SRCSEL = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_FREQSEL = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_SLIP = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_PRESET = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_FBLOW = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_FBHIGH = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_RESTORE = 4'hA;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'hB;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hC;
    localparam logic [ADDR_W-1:0] ADDR_OUTFREQ = 4'hD;

    // ==============================
    // ranges and reset values (gains in 0.01, percentages in 0.1 %, frequency in 0.01 Hz)
    localparam logic [DATA_W-1:0] GAIN_MAX = 16'h03E8;
    localparam logic [DATA_W-1:0] GAIN_RST = 16'h0001;
    localparam logic [DATA_W-1:0] SETPT_MAX = 16'h03E8;
    localparam logic [DATA_W-1:0] SETPT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DEADB_MAX = 16'h0064;
    localparam logic [DATA_W-1:0] DEADB_RST = 16'h0000;
    localparam logic [DATA_W-1:0] SRCSEL_MAX = 16'h0009;
    localparam logic [DATA_W-1:0] SRCSEL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] FREQSEL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] SLIP_RST = 16'h0000;
    localparam logic [DATA_W-1:0] PRESET_RST = 16'h0000;
    localparam logic [DATA_W-1:0] FBLOW_RST = 16'h0000;
    localparam logic [DATA_W-1:0] FBHIGH_RST = 16'h03E8;
    localparam logic [DATA_W-1:0] CONFIG_RST = 16'h0001;
    localparam logic [DATA_W-1:0] FREQ_MAX = 16'h9C40;
    localparam logic [DATA_W-1:0] PCT_FULL = 16'h03E8;

    // ==============================
    // selector values and commands
    localparam logic [DATA_W-1:0] SEL_LAST_EXT = 16'h0006;
    localparam logic [DATA_W-1:0] SEL_CONTACT = 16'h0007;
    localparam logic [DATA_W-1:0] SEL_UNUSED = 16'h0008;
    localparam logic [DATA_W-1:0] SEL_PI = 16'h0009;
    localparam logic [DATA_W-1:0] FREQSEL_EXT = 16'h0000;
    localparam logic [DATA_W-1:0] RESTORE_ALL = 16'h0001;
    localparam logic [DATA_W-1:0] RESTORE_SEL = 16'h0002;

    // ==============================
    // field positions
    localparam int CFG_NEWEST = 0;
    localparam int ST_FAULT = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_RUN = 2;
    localparam int ST_INHIBIT = 3;

    // ==============================
    // timing: regulator update tick and gain scaling
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_SEC = 1000000000 / TICK_PERIOD_NS;
    localparam int P_DIV = 10;
    localparam int I_SCALE = TICKS_PER_SEC;
    localparam int IACC_LIM = 40000 * TICKS_PER_SEC;

    // ==============================
    // carrier of the terminal contacts
    typedef struct packed {
        logic startClosed;
        logic inhibitClosed;
        logic stopPressed;
    } pireg_term_s;

endpackage

// ==== src/pireg_tick_div.sv ====
// divider making the one-cycle regulator update enable
`timescale 1ns/1ns
`default_nettype none
module pireg_tick_div
    import pireg_pkg::*;
#(
    parameter int unsigned CYC = TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // enable out
    output logic tick
);
    logic [31:0] count_q;

    // ==============================
    // free-running count, tick on wrap
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= 32'h00000000;
            tick <= 1'b0;
        end else if (count_q >= CYC - 1) begin
            count_q <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            count_q <= count_q + 32'h00000001;
            tick <= 1'b0;
        end
    end

    AST_TICK_ONE: assert property (@(posedge sys_clk) disable iff (rst) tick |=> !tick)
        else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// ==== src/pireg_fb_scale.sv ====
// feedback scaling onto the process range, with inversion when high is below low
`timescale 1ns/1ns
`default_nettype none
module pireg_fb_scale
    import pireg_pkg::*;
(
    // feedback and scaling settings
    input wire logic [DATA_W-1:0] rawFb,
    input wire logic [DATA_W-1:0] scaleLow,
    input wire logic [DATA_W-1:0] scaleHigh,
    // scaled percentage, 0.1 % units
    output logic [DATA_W-1:0] scaledFb
);
    logic inverted;
    logic [DATA_W-1:0] span;
    logic [DATA_W-1:0] offs;
    logic [31:0] quot;

    always_comb begin
        inverted = scaleHigh < scaleLow; // RL21
        span = inverted ? scaleLow - scaleHigh : scaleHigh - scaleLow;
        if (inverted) begin
            // rising feedback lowers the result
            offs = (rawFb >= scaleLow) ? 16'h0000 : (rawFb <= scaleHigh ? span : scaleLow - rawFb); // RL19
        end else begin
            offs = (rawFb <= scaleLow) ? 16'h0000 : (rawFb >= scaleHigh ? span : rawFb - scaleLow); // RL19
        end
        // a zero span would divide by zero; read it as no feedback
        quot = (span == 16'h0000) ? 32'h00000000 : ({16'h0000, offs} * {16'h0000, PCT_FULL}) / {16'h0000, span};
        scaledFb = quot[DATA_W-1:0];
    end
endmodule
`default_nettype wire

// ==== src/pireg_top.sv ====
// process regulator: settings, activation, terminal contacts and frequency correction
//
// Notes on behaviour
// RL1: proportional gain 1.00 gives 1 Hz correction per 1 % error.
// RL2: integral gain 1.00 ramps correction 10 Hz per second at 1 % error.
// RL3: proportional gain 0 to 10.00 in 0.01 steps, default 0.01.
// RL4: integral gain 0 to 10.00 in 0.01 steps, default 0.01.
// RL5: setpoint 0 to 100.0 % in 0.1 % steps, default zero.
// RL6: errors below the dead band, 0 to 10.0 %, are ignored.
// RL7: gains, setpoint and dead band act when the selector is 9.
// RL8: newest revision also activates through setpoint and slip compensation.
// RL9: newest revision needs setpoint above zero unless selector is 9.
// RL10: operator disables the regulator only while the drive is stopped; here restore 2 and setting writes act whether or not the drive is stopped.
// RL11: start or run honoured only while start contact is closed.
// RL12: restore 1 resets settings and raises fault; stop cycling clears it.
// RL13: selector change acts after reset or restore command 2.
// RL14: selector 0 to 6 needs frequency source 0; 8 never regulates.
// RL15: selector 7 and 9 use the opened inhibit contact.
// RL16: older revisions regulate only with selector 9.
// RL17: closed inhibit contact disables regulation and outputs the preset frequency.
// RL18: opening inhibit enters regulation for selector 7 or 9.
// RL19: feedback low and high scaling map, and may invert, the feedback.
// RL20: installer wires feedback so that rising feedback asks for rising frequency; here rising scaled feedback lowers the frequency command.
// RL21: high scaling below low scaling inverts the feedback.
// RL22: error is setpoint minus feedback; proportional plus integral added to command.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module pireg_top
    import pireg_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // terminal contacts, asynchronous pins
    input wire pireg_term_s termPins,
    // process signals from same-clock logic
    input wire logic [DATA_W-1:0] feedbackRaw,
    input wire logic [DATA_W-1:0] extFreqCmd,
    // frequency command to the motor stage
    output logic [DATA_W-1:0] freqCmd,
    output logic runCmd,
    output logic regActive,
    output logic reprogramFault
);
    // ==============================
    // settings
    logic [DATA_W-1:0] pGain_q;
    logic [DATA_W-1:0] iGain_q;
    logic [DATA_W-1:0] setpoint_q;
    logic [DATA_W-1:0] deadband_q;
    logic [DATA_W-1:0] srcSel_q;
    logic [DATA_W-1:0] activeSel_q;
    logic [DATA_W-1:0] freqSel_q;
    logic [DATA_W-1:0] slipComp_q;
    logic [DATA_W-1:0] presetFreq_q;
    logic [DATA_W-1:0] fbLow_q;
    logic [DATA_W-1:0] fbHigh_q;
    logic [DATA_W-1:0] config_q;

    // contacts and strobes
    pireg_term_s termMeta_q;
    pireg_term_s term_q;
    logic stopPrev_q;
    logic stopRelease;
    logic wrRestoreAll;
    logic wrRestoreSel;

    // loop terms are 32 bits wide so gain times error never wraps
    logic tick;
    logic regOn;
    logic [DATA_W-1:0] fbScaled;
    logic signed [31:0] iAcc_q;
    logic signed [31:0] err;
    logic signed [31:0] errDb;
    logic signed [31:0] pTerm;
    logic signed [31:0] iStep;
    logic signed [31:0] iNext;
    logic signed [31:0] total;

    function automatic logic [DATA_W-1:0] clampTo(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] lim);
        clampTo = (v > lim) ? lim : v;
    endfunction

    assign wrRestoreAll = regWrite && regAddr == ADDR_RESTORE && regWdata == RESTORE_ALL;
    assign wrRestoreSel = regWrite && regAddr == ADDR_RESTORE && regWdata == RESTORE_SEL;

    // ==============================
    // pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            termMeta_q <= '0;
            term_q <= '0;
            stopPrev_q <= 1'b0;
        end else begin
            termMeta_q <= termPins;
            term_q <= termMeta_q;
            stopPrev_q <= term_q.stopPressed;
        end
    end
    assign stopRelease = stopPrev_q && !term_q.stopPressed;

    pireg_tick_div #(.CYC(TICK_CYCLES)) uTick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );

    pireg_fb_scale uScale (
        .rawFb(feedbackRaw),
        .scaleLow(fbLow_q),
        .scaleHigh(fbHigh_q),
        .scaledFb(fbScaled)
    );

    // ==============================
    // settings registers; gain, setpoint, dead band, selector and preset writes clamped to their ranges
    always_ff @(posedge sys_clk) begin
        if (rst || wrRestoreAll) begin // RL12
            pGain_q <= GAIN_RST; // RL3
            iGain_q <= GAIN_RST; // RL4
            setpoint_q <= SETPT_RST; // RL5
            deadband_q <= DEADB_RST; // RL6
            srcSel_q <= SRCSEL_RST;
            freqSel_q <= FREQSEL_RST;
            slipComp_q <= SLIP_RST;
            presetFreq_q <= PRESET_RST;
            fbLow_q <= FBLOW_RST;
            fbHigh_q <= FBHIGH_RST;
            config_q <= CONFIG_RST;
        end else if (regWrite) begin
            if (regAddr == ADDR_PGAIN) begin
                pGain_q <= clampTo(regWdata, GAIN_MAX); // RL3
            end else if (regAddr == ADDR_IGAIN) begin
                iGain_q <= clampTo(regWdata, GAIN_MAX); // RL4
            end else if (regAddr == ADDR_SETPT) begin
                setpoint_q <= clampTo(regWdata, SETPT_MAX); // RL5
            end else if (regAddr == ADDR_DEADB) begin
                deadband_q <= clampTo(regWdata, DEADB_MAX); // RL6
            end else if (regAddr == ADDR_SRCSEL) begin
                srcSel_q <= clampTo(regWdata, SRCSEL_MAX);
            end else if (regAddr == ADDR_FREQSEL) begin
                freqSel_q <= regWdata;
            end else if (regAddr == ADDR_SLIP) begin
                slipComp_q <= regWdata;
            end else if (regAddr == ADDR_PRESET) begin
                presetFreq_q <= clampTo(regWdata, FREQ_MAX);
            end else if (regAddr == ADDR_FBLOW) begin
                fbLow_q <= regWdata;
            end else if (regAddr == ADDR_FBHIGH) begin
                fbHigh_q <= regWdata;
            end else if (regAddr == ADDR_CONFIG) begin
                config_q <= regWdata & 16'h0001;
            end
        end
    end

    // ==============================
    // selector in force: only reset or restore 2 moves it, so a live edit cannot jolt the motor
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            activeSel_q <= SRCSEL_RST; // RL13
        end else if (wrRestoreSel) begin
            activeSel_q <= srcSel_q; // RL13
        end
    end

    // ==============================
    // reprogram fault: set wins over the stop-release clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reprogramFault <= 1'b0;
        end else if (wrRestoreAll) begin
            reprogramFault <= 1'b1; // RL12
        end else if (stopRelease) begin
            reprogramFault <= 1'b0; // RL12
        end
    end

    // ==============================
    // activation
    always_comb begin
        regOn = 1'b0;
        if (activeSel_q == SEL_PI) begin
            regOn = !term_q.inhibitClosed; // RL7 RL15 RL18
        end else if (config_q[CFG_NEWEST] && activeSel_q != SEL_UNUSED) begin // RL14 RL16
            // slip compensation at zero and a live setpoint together arm the loop
            regOn = slipComp_q == SLIP_RST && setpoint_q != SETPT_RST; // RL8 RL9
            if (activeSel_q <= SEL_LAST_EXT) begin
                regOn = regOn && freqSel_q == FREQSEL_EXT && !term_q.inhibitClosed; // RL14 RL17
            end else begin
                regOn = regOn && !term_q.inhibitClosed; // RL15 RL18
            end
        end
        regOn = regOn && term_q.startClosed && !reprogramFault;
    end

    // ==============================
    // error and correction terms
    always_comb begin
        err = $signed({16'h0000, setpoint_q}) - $signed({16'h0000, fbScaled}); // RL22
        if (err < $signed({16'h0000, deadband_q}) && -err < $signed({16'h0000, deadband_q})) begin
            errDb = 32'sh00000000; // RL6
        end else begin
            errDb = err;
        end
        // 0.01 gain x 0.1 % error gives 0.001 Hz, so divide by 10 for 0.01 Hz
        pTerm = ($signed({16'h0000, pGain_q}) * errDb) / P_DIV; // RL1
        // per tick step kept scaled by ticks per second; 1.00 at 1 % gives 10 Hz/s
        iStep = $signed({16'h0000, iGain_q}) * errDb; // RL2
        iNext = iAcc_q + iStep;
        if (iNext > IACC_LIM) begin
            iNext = IACC_LIM;
        end else if (iNext < -IACC_LIM) begin
            iNext = -IACC_LIM;
        end
        total = $signed({16'h0000, extFreqCmd}) + pTerm + iAcc_q / I_SCALE; // RL22
    end

    // ==============================
    // integrator, cleared while the loop is off to avoid windup at re-entry
    always_ff @(posedge sys_clk) begin
        if (rst || !regOn) begin
            iAcc_q <= 32'sh00000000;
        end else if (tick) begin
            iAcc_q <= iNext; // RL2 RL22
        end
    end

    // ==============================
    // outputs to the motor stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            runCmd <= 1'b0;
            regActive <= 1'b0;
            freqCmd <= 16'h0000;
        end else begin
            runCmd <= term_q.startClosed && !term_q.stopPressed && !reprogramFault; // RL11
            regActive <= regOn;
            if (!term_q.startClosed) begin
                freqCmd <= 16'h0000; // RL11
            end else if (term_q.inhibitClosed) begin
                freqCmd <= presetFreq_q; // RL17
            end else if (!regOn) begin
                freqCmd <= clampTo(extFreqCmd, FREQ_MAX);
            end else if (total < 0) begin
                freqCmd <= 16'h0000;
            end else if (total > $signed({16'h0000, FREQ_MAX})) begin
                freqCmd <= FREQ_MAX;
            end else begin
                freqCmd <= total[DATA_W-1:0]; // RL22
            end
        end
    end

    // ==============================
    // register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdata <= 16'h0000;
        end else if (regRead) begin
            if (regAddr == ADDR_PGAIN) begin
                regRdata <= pGain_q;
            end else if (regAddr == ADDR_IGAIN) begin
                regRdata <= iGain_q;
            end else if (regAddr == ADDR_SETPT) begin
                regRdata <= setpoint_q;
            end else if (regAddr == ADDR_DEADB) begin
                regRdata <= deadband_q;
            end else if (regAddr == ADDR_SRCSEL) begin
                regRdata <= srcSel_q;
            end else if (regAddr == ADDR_FREQSEL) begin
                regRdata <= freqSel_q;
            end else if (regAddr == ADDR_SLIP) begin
                regRdata <= slipComp_q;
            end else if (regAddr == ADDR_PRESET) begin
                regRdata <= presetFreq_q;
            end else if (regAddr == ADDR_FBLOW) begin
                regRdata <= fbLow_q;
            end else if (regAddr == ADDR_FBHIGH) begin
                regRdata <= fbHigh_q;
            end else if (regAddr == ADDR_CONFIG) begin
                regRdata <= config_q;
            end else if (regAddr == ADDR_STATUS) begin
                regRdata <= {12'h000, term_q.inhibitClosed, runCmd, regActive, reprogramFault};
            end else if (regAddr == ADDR_OUTFREQ) begin
                regRdata <= freqCmd;
            end else begin
                regRdata <= 16'h0000;
            end
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // ==============================
    // checks
    sequence seqRestoreAll;
        regWrite && regAddr == ADDR_RESTORE && regWdata == RESTORE_ALL;
    endsequence

    sequence seqDefaultsSeen;
        pGain_q == GAIN_RST && iGain_q == GAIN_RST && setpoint_q == SETPT_RST ##0 reprogramFault;
    endsequence

    AST_RESTORE_DEFAULTS: assert property (@(posedge sys_clk) disable iff (rst) seqRestoreAll |=> seqDefaultsSeen) // RL12
        else $error("restore did not reload defaults and raise fault");
    AST_PGAIN_RANGE: assert property (@(posedge sys_clk) disable iff (rst) pGain_q <= GAIN_MAX) // RL3
        else $error("proportional gain out of range");
    AST_IGAIN_RANGE: assert property (@(posedge sys_clk) disable iff (rst) iGain_q <= GAIN_MAX) // RL4
        else $error("integral gain out of range");
    AST_SETPT_RANGE: assert property (@(posedge sys_clk) disable iff (rst) setpoint_q <= SETPT_MAX) // RL5
        else $error("setpoint out of range");
    AST_DEADB_RANGE: assert property (@(posedge sys_clk) disable iff (rst) deadband_q <= DEADB_MAX) // RL6
        else $error("dead band out of range");
    AST_SEL_HOLD: assert property (@(posedge sys_clk) disable iff (rst) !wrRestoreSel |=> $stable(activeSel_q)) // RL13
        else $error("selector in force changed without restore");
    AST_START_GATE: assert property (@(posedge sys_clk) disable iff (rst) !term_q.startClosed |=> !runCmd && freqCmd == 16'h0000) // RL11
        else $error("run without start contact");
    AST_INHIBIT_PRESET: assert property (@(posedge sys_clk) disable iff (rst) // RL17
        term_q.startClosed && term_q.inhibitClosed |=> freqCmd == $past(presetFreq_q) && !regActive)
        else $error("inhibit did not force preset frequency");
    AST_SEL8_OFF: assert property (@(posedge sys_clk) disable iff (rst) activeSel_q == SEL_UNUSED |=> !regActive) // RL14
        else $error("regulator active with selector 8");
    AST_OLD_ONLY9: assert property (@(posedge sys_clk) disable iff (rst) // RL16
        !config_q[CFG_NEWEST] && activeSel_q != SEL_PI |=> !regActive)
        else $error("older revision regulating without selector 9");
    AST_FAULT_CLEAR: assert property (@(posedge sys_clk) disable iff (rst) // RL12
        stopRelease && !wrRestoreAll |=> !reprogramFault)
        else $error("stop cycling did not clear fault");
    AST_FAULT_NO_RUN: assert property (@(posedge sys_clk) disable iff (rst) // RL12
        reprogramFault |=> !runCmd)
        else $error("run command raised under reprogram fault");
endmodule
`default_nettype wire

// ==== verification/pireg_plant.sv ====
// feedback transducer model on the far side of the regulator output
`timescale 1ns/1ns
`default_nettype none
module pireg_plant
    import pireg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // motor stage side
    input wire logic [DATA_W-1:0] freqCmd,
    input wire logic runCmd,
    // bench control: hold gives a fixed reading, else a lagging process
    input wire logic fbHold,
    input wire logic [DATA_W-1:0] fbSet,
    output logic [DATA_W-1:0] feedbackRaw
);
    logic [DATA_W-1:0] procLvl_q;
    // ==============================
    // process: one step a cycle, so the loop sees a slow plant
    always_ff @(posedge sys_clk) begin
        if (rst || !runCmd) begin
            procLvl_q <= '0;
        end else if (procLvl_q < freqCmd / 16'h0028) begin
            procLvl_q <= procLvl_q + 16'h0001;
        end else if (procLvl_q > freqCmd / 16'h0028) begin
            procLvl_q <= procLvl_q - 16'h0001;
        end
    end
    assign feedbackRaw = fbHold ? fbSet : procLvl_q;
endmodule
`default_nettype wire

// ==== verification/pireg_top_tb.sv ====
// self-checking bench of the process regulator
`timescale 1ns/1ns
`default_nettype none
module pireg_top_tb
    import pireg_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst, regWrite, regRead, runCmd, regActive, reprogramFault, fbHold;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, feedbackRaw, extFreqCmd, freqCmd, fbSet;
    pireg_term_s termPins;
    int err_count = 0;
    int checks = 0;
    int seed = 32'hbfd87eef;
    // sel, freq source, slip, newest, setpoint, expected active
    int tab[8][6] = '{'{9, 1, 5, 0, 0, 1}, '{7, 0, 0, 1, 200, 1}, '{7, 0, 0, 1, 0, 0}, '{7, 0, 0, 0, 200, 0},
        '{0, 0, 0, 1, 200, 1}, '{6, 1, 0, 1, 200, 0}, '{3, 0, 5, 1, 200, 0}, '{8, 0, 0, 1, 200, 0}};
    always #5 sys_clk = ~sys_clk;
    pireg_top #(.TICK_CYCLES(10)) u_dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .termPins(termPins),
        .feedbackRaw(feedbackRaw), .extFreqCmd(extFreqCmd), .freqCmd(freqCmd), .runCmd(runCmd),
        .regActive(regActive), .reprogramFault(reprogramFault));
    pireg_plant u_plant (.sys_clk(sys_clk), .rst(rst), .freqCmd(freqCmd), .runCmd(runCmd), .fbHold(fbHold),
        .fbSet(fbSet), .feedbackRaw(feedbackRaw));
    // ==============================
    // tasks
    task automatic conclude;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check(regRdata, exp);
    endtask
    // pins need three edges; eight leaves margin
    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [15:0] expFreq(int ext, int kp, int fb, int db);
        int e;
        e = 500 - fb;
        if (e < db && -e < db) begin
            e = 0;
        end
        return 16'(ext + kp * e / 10);
    endfunction
    // ==============================
    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude;
    end
    // ==============================
    // main sequence
    initial begin
        int kp, fb, db, ext;
        logic [15:0] a;
        rst = 1'b1;
        regAddr = '0;
        regWdata = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        fbHold = 1'b1;
        fbSet = 16'h01F4;
        extFreqCmd = 16'h1388;
        termPins = '{startClosed: 1'b1, inhibitClosed: 1'b1, stopPressed: 1'b0};
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(ADDR_PGAIN, GAIN_RST);
        rdchk(ADDR_IGAIN, GAIN_RST);
        rdchk(ADDR_SETPT, SETPT_RST);
        rdchk(ADDR_DEADB, DEADB_RST);
        rdchk(4'hE, 16'h0000);
        wr(ADDR_PGAIN, 16'hFFFF);
        rdchk(ADDR_PGAIN, GAIN_MAX);
        wr(ADDR_SETPT, 16'h07D0);
        rdchk(ADDR_SETPT, SETPT_MAX);
        wr(ADDR_DEADB, 16'h0065);
        rdchk(ADDR_DEADB, DEADB_MAX);
        wr(ADDR_RESTORE, RESTORE_ALL);
        settle;
        check({15'h0, reprogramFault}, 16'h0001);
        check({15'h0, runCmd}, 16'h0000);
        rdchk(ADDR_PGAIN, GAIN_RST);
        termPins.stopPressed <= 1'b1;
        settle;
        termPins.stopPressed <= 1'b0;
        settle;
        check({15'h0, reprogramFault}, 16'h0000);
        // integrator off so proportional results are exact
        wr(ADDR_IGAIN, 16'h0000);
        wr(ADDR_PGAIN, 16'h0064);
        wr(ADDR_SETPT, 16'h01F4);
        wr(ADDR_PRESET, 16'h04D2);
        settle;
        check(freqCmd, 16'h04D2);
        check({15'h0, regActive}, 16'h0000);
        check({15'h0, runCmd}, 16'h0001);
        termPins.inhibitClosed <= 1'b0;
        settle;
        check({15'h0, regActive}, 16'h0001);
        wr(ADDR_SRCSEL, SEL_UNUSED);
        settle;
        check({15'h0, regActive}, 16'h0001);
        wr(ADDR_RESTORE, RESTORE_SEL);
        settle;
        check({15'h0, regActive}, 16'h0000);
        wr(ADDR_SRCSEL, SEL_PI);
        wr(ADDR_RESTORE, RESTORE_SEL);
        settle;
        check({15'h0, regActive}, 16'h0001);
        // first two passes sit on the dead band edge: error 99 then 100
        for (int i = 0; i < 8; i++) begin
            kp = (i < 2) ? 100 : 10 * ($unsigned($random(seed)) % 101);
            fb = (i < 2) ? 401 - i : 400 + $unsigned($random(seed)) % 201;
            db = (i < 2) ? 100 : $unsigned($random(seed)) % 101;
            ext = 10000 + $unsigned($random(seed)) % 20000;
            wr(ADDR_PGAIN, 16'(kp));
            wr(ADDR_DEADB, 16'(db));
            fbSet <= 16'(fb);
            extFreqCmd <= 16'(ext);
            settle;
            check(freqCmd, expFreq(ext, kp, fb, db));
        end
        wr(ADDR_PGAIN, 16'h0064);
        wr(ADDR_DEADB, 16'h0000);
        wr(ADDR_FBLOW, PCT_FULL);
        wr(ADDR_FBHIGH, 16'h0000);
        fbSet <= 16'h0190;
        settle;
        check(freqCmd, expFreq(ext, 100, 600, 0));
        wr(ADDR_FBLOW, FBLOW_RST);
        wr(ADDR_FBHIGH, FBHIGH_RST);
        // closed loop through the plant: 200.00 Hz settles it at 50.0 %
        fbHold <= 1'b0;
        extFreqCmd <= 16'h4E20;
        repeat (1000) @(posedge sys_clk);
        #1;
        check(feedbackRaw, 16'h01F4);
        check(freqCmd, 16'h4E20);
        rdchk(ADDR_OUTFREQ, 16'h4E20);
        rdchk(ADDR_STATUS, 16'h0006);
        fbHold <= 1'b1;
        // one percent error at gain 1.00: one step of 0.01 Hz per tick of 10 cycles
        wr(ADDR_PGAIN, 16'h0000);
        wr(ADDR_IGAIN, 16'h0064);
        fbSet <= 16'h01EA;
        settle;
        a = freqCmd;
        repeat (200) @(posedge sys_clk);
        #1;
        a = freqCmd - a;
        check((a >= 16'd19 && a <= 16'd21) ? 16'h0001 : 16'h0000, 16'h0001);
        wr(ADDR_IGAIN, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            termPins.stopPressed <= 1'b1;
            wr(ADDR_SRCSEL, 16'(tab[i][0]));
            wr(ADDR_FREQSEL, 16'(tab[i][1]));
            wr(ADDR_SLIP, 16'(tab[i][2]));
            wr(ADDR_CONFIG, 16'(tab[i][3]));
            wr(ADDR_SETPT, 16'(tab[i][4]));
            wr(ADDR_RESTORE, RESTORE_SEL);
            termPins.stopPressed <= 1'b0;
            settle;
            check({15'h0, regActive}, 16'(tab[i][5]));
        end
        termPins.startClosed <= 1'b0;
        settle;
        check({15'h0, runCmd}, 16'h0000);
        check(freqCmd, 16'h0000);
        conclude;
    end
endmodule
`default_nettype wire
